// ---- pcs_host.sv ----
`timescale 1ns/1ns
module pcs_host(input wire logic clk, oe_n, drv, pull, kick_en, output logic pin, output logic kick = 1'b0);
  assign pin = (oe_n | drv) & ~pull;
  always @(posedge clk) kick <= kick_en & pin & ~kick;
endmodule // pcs_host

// ---- pcs_pkg.sv ----
package pcs_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          TICK_W          = 17;

  // reset pulse length after the cause goes away
  localparam int unsigned RESET_HOLD_MS   = 100;
  localparam int          HOLD_W          = 7;

  // watchdog span: period input counts steps of 100 ms
  localparam int unsigned WD_STEP_MS      = 100;
  localparam int unsigned WD_MIN_MS       = 100;
  localparam int unsigned WD_MAX_MS       = 3000;
  localparam int          WD_SEL_W        = 5;
  localparam int          WD_W            = 12;
  localparam logic [WD_SEL_W-1:0] WD_SEL_MIN = WD_SEL_W'(WD_MIN_MS / WD_STEP_MS);
  localparam logic [WD_SEL_W-1:0] WD_SEL_MAX = WD_SEL_W'(WD_MAX_MS / WD_STEP_MS);

  // manual reset debounce: consecutive low samples on the time base
  localparam int unsigned DEBOUNCE_MS     = 4;
  localparam int          DEB_W           = 3;

  // calibration square wave
  localparam int unsigned CAL_HZ          = 512;
  localparam int unsigned CAL_HALF_CYCLES = CLK_HZ / (2 * CAL_HZ);
  localparam int          CAL_W           = 17;

  // event counters and serial number
  localparam int          EVT_W           = 16;
  localparam int          SN_W            = 64;

  // reset values
  localparam logic [EVT_W-1:0] EVT_RESET  = 16'h0000;
  localparam logic [SN_W-1:0]  SN_RESET   = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    PCS_RUN   = 2'b00,
    PCS_HOLD  = 2'b01
  } pcs_rst_state_t;

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    pcs_rst_state_t    rst_state;
    logic [HOLD_W-1:0] hold_cnt;
    logic [WD_W-1:0]   wd_cnt;
    logic [DEB_W-1:0]  deb_cnt;
    logic              by_watchdog;
    logic              prev_a;
    logic              prev_b;
    logic [EVT_W-1:0]  count_a;
    logic [EVT_W-1:0]  count_b;
    logic [SN_W-1:0]   serial;
    logic              locked;
    logic [CAL_W-1:0]  cal_cnt;
    logic              cal_wave;
    logic              warn;
    logic              drive_n;
  } pcs_state_t;

endpackage

// ---- pcs_supervisor.sv ----
`timescale 1ns/1ns

module pcs_supervisor #(
  parameter int unsigned TICK_CYCLES     = pcs_pkg::TICK_CYCLES,
  parameter int unsigned CAL_HALF_CYCLES = pcs_pkg::CAL_HALF_CYCLES
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             vdd_below_trip,
  input  wire logic                             wd_enable,
  input  wire logic [pcs_pkg::WD_SEL_W-1:0]     wd_period,
  input  wire logic                             wd_restart,
  input  wire logic                             rst_pin_in,
  output logic                                  rst_pin_out,
  output logic                                  rst_pin_oe_n,
  output logic                                  reset_by_watchdog,
  input  wire logic                             early_fail_sense_in,
  input  wire logic                             cal_mode,
  output logic                                  early_fail_warn_out,
  input  wire logic                             event_count_in_a,
  input  wire logic                             event_count_in_b,
  input  wire logic                             count_falling_a,
  input  wire logic                             count_falling_b,
  output logic [pcs_pkg::EVT_W-1:0]             event_count_a,
  output logic [pcs_pkg::EVT_W-1:0]             event_count_b,
  input  wire logic                             serial_wr,
  input  wire logic [pcs_pkg::SN_W-1:0]         serial_wr_data,
  input  wire logic                             serial_lock,
  output logic [pcs_pkg::SN_W-1:0]              serial_number,
  output logic                                  serial_locked
);

  localparam logic [pcs_pkg::TICK_W-1:0] TICK_LAST = pcs_pkg::TICK_W'(TICK_CYCLES - 1);
  localparam logic [pcs_pkg::CAL_W-1:0]  CAL_LAST  = pcs_pkg::CAL_W'(CAL_HALF_CYCLES - 1);
  localparam logic [pcs_pkg::HOLD_W-1:0] HOLD_LAST = pcs_pkg::HOLD_W'(pcs_pkg::RESET_HOLD_MS - 1);
  localparam logic [pcs_pkg::DEB_W-1:0]  DEB_LAST  = pcs_pkg::DEB_W'(pcs_pkg::DEBOUNCE_MS - 1);
  localparam logic [pcs_pkg::WD_W-1:0]   WD_STEP   = pcs_pkg::WD_W'(pcs_pkg::WD_STEP_MS);

  // edge seen on a counter input in the chosen direction
  function automatic logic pcs_edge(input logic prev, input logic now, input logic falling);
    pcs_edge = falling ? (prev & ~now) : (~prev & now);
  endfunction

  // power-up value: reset released, counters and serial number cleared
  localparam pcs_pkg::pcs_state_t STATE_RESET = '{
    tick_cnt:    '0,
    tick:        1'b0,
    rst_state:   pcs_pkg::PCS_RUN,
    hold_cnt:    '0,
    wd_cnt:      '0,
    deb_cnt:     '0,
    by_watchdog: 1'b0,
    prev_a:      1'b0,
    prev_b:      1'b0,
    count_a:     pcs_pkg::EVT_RESET,
    count_b:     pcs_pkg::EVT_RESET,
    serial:      pcs_pkg::SN_RESET,
    locked:      1'b0,
    cal_cnt:     '0,
    cal_wave:    1'b0,
    warn:        1'b0,
    drive_n:     1'b1
  };

  pcs_pkg::pcs_state_t               s;
  pcs_pkg::pcs_state_t               next_s;
  logic [pcs_pkg::WD_SEL_W-1:0]      wd_sel;
  logic [pcs_pkg::WD_W-1:0]          wd_limit;
  logic [pcs_pkg::WD_W-1:0]          wd_last;
  logic                              wd_expire;
  logic                              mr_start;

  always_comb begin
    next_s    = s;
    wd_sel    = wd_period;
    wd_limit  = '0;
    wd_last   = '0;
    wd_expire = 1'b0;
    mr_start  = 1'b0;

    // millisecond time base
    next_s.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 1'b1;
    end

    // period outside the span is clamped to its nearest end
    if (wd_period < pcs_pkg::WD_SEL_MIN) begin
      wd_sel = pcs_pkg::WD_SEL_MIN;
    end else if (wd_period > pcs_pkg::WD_SEL_MAX) begin
      wd_sel = pcs_pkg::WD_SEL_MAX;
    end else begin
      wd_sel = wd_period;
    end
    wd_limit = pcs_pkg::WD_W'(wd_sel) * WD_STEP;
    wd_last  = wd_limit - pcs_pkg::WD_W'(1);

    // watchdog: idle when disabled, restarted, or during a pulse
    if (!wd_enable || wd_restart || s.rst_state != pcs_pkg::PCS_RUN) begin
      next_s.wd_cnt = '0;
    end else if (s.tick) begin
      if (s.wd_cnt == wd_last) begin
        wd_expire     = 1'b1;
        next_s.wd_cnt = '0;
      end else begin
        next_s.wd_cnt = s.wd_cnt + 1'b1;
      end
    end

    // manual reset: pin must read low on consecutive time base samples
    if (!s.drive_n || rst_pin_in) begin
      next_s.deb_cnt = '0;
    end else if (s.tick) begin
      if (s.deb_cnt == DEB_LAST) begin
        mr_start       = 1'b1;
        next_s.deb_cnt = '0;
      end else begin
        next_s.deb_cnt = s.deb_cnt + 1'b1;
      end
    end

    // reset pulse sequencing
    case (s.rst_state)
      pcs_pkg::PCS_RUN: begin
        if (vdd_below_trip || wd_expire || mr_start) begin
          next_s.rst_state = pcs_pkg::PCS_HOLD;
          next_s.hold_cnt  = '0;
        end
      end
      pcs_pkg::PCS_HOLD: begin
        if (vdd_below_trip) begin
          next_s.hold_cnt = '0;
        end else if (s.tick) begin
          if (s.hold_cnt == HOLD_LAST) begin
            next_s.rst_state = pcs_pkg::PCS_RUN;
            next_s.hold_cnt  = '0;
          end else begin
            next_s.hold_cnt = s.hold_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_s.rst_state = pcs_pkg::PCS_RUN;
        next_s.hold_cnt  = '0;
      end
    endcase
    next_s.drive_n = (next_s.rst_state == pcs_pkg::PCS_RUN);

    // watchdog flag: set on expiry, cleared by low supply, which takes precedence; a manual reset leaves it unchanged
    if (wd_expire) begin
      next_s.by_watchdog = 1'b1;
    end
    if (vdd_below_trip) begin
      next_s.by_watchdog = 1'b0;
    end

    // event counters
    next_s.prev_a = event_count_in_a;
    next_s.prev_b = event_count_in_b;
    if (pcs_edge(s.prev_a, event_count_in_a, count_falling_a)) begin
      next_s.count_a = s.count_a + 1'b1;
    end
    if (pcs_edge(s.prev_b, event_count_in_b, count_falling_b)) begin
      next_s.count_b = s.count_b + 1'b1;
    end

    // serial number; a write in the lock cycle still lands
    if (serial_wr && !s.locked) begin
      next_s.serial = serial_wr_data;
    end
    if (serial_lock) begin
      next_s.locked = 1'b1;
    end

    // calibration square wave
    if (s.cal_cnt == CAL_LAST) begin
      next_s.cal_cnt  = '0;
      next_s.cal_wave = ~s.cal_wave;
    end else begin
      next_s.cal_cnt = s.cal_cnt + 1'b1;
    end

    // shared pin: square wave in calibration, otherwise warning
    // sense high means above the reference
    if (cal_mode) begin
      next_s.warn = s.cal_wave;
    end else begin
      next_s.warn = ~early_fail_sense_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // open drain: only ever pulls low
  assign rst_pin_out         = 1'b0;
  assign rst_pin_oe_n        = s.drive_n;
  assign reset_by_watchdog   = s.by_watchdog;
  assign early_fail_warn_out = s.warn;
  assign event_count_a       = s.count_a;
  assign event_count_b       = s.count_b;
  assign serial_number       = s.serial;
  assign serial_locked       = s.locked;

endmodule // pcs_supervisor

// ---- pcs_sva.sv ----
`timescale 1ns/1ns
module pcs_sva(input wire logic clk, rst, vdd_below_trip, wd_enable, rst_pin_in, rst_pin_out, rst_pin_oe_n,
  early_fail_sense_in, cal_mode, early_fail_warn_out, serial_wr, serial_locked,
  input wire logic [15:0] event_count_a, input wire logic [63:0] serial_number);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_supply_low: assert property (vdd_below_trip |-> ##[0:30] !rst_pin_oe_n) else $error("late");
  a_hold_min: assert property ($fell(vdd_below_trip) |-> !rst_pin_oe_n [*8]) else $error("hold");
  a_drain_only: assert property (!rst_pin_oe_n |-> !rst_pin_out) else $error("high");
  a_warn_steady: assert property ((!cal_mode && $stable(early_fail_sense_in)) [*8]
    |=> $stable(early_fail_warn_out)) else $error("warn");
  a_lock_sticky: assert property (serial_locked |=> serial_locked) else $error("lock");
  a_write_ignored: assert property (serial_locked && serial_wr |=> $stable(serial_number)) else $error("sn");
  a_glitch_filter: assert property ($fell(rst_pin_in) && rst_pin_oe_n && !vdd_below_trip && !wd_enable
    |=> rst_pin_oe_n [*3]) else $error("glitch");
  a_count_step: assert property ($changed(event_count_a) |-> event_count_a == $past(event_count_a) + 16'h0001)
    else $error("step");
  c_wd: cover property ($fell(rst_pin_oe_n) && wd_enable);
  c_glitch: cover property ($fell(rst_pin_in) && rst_pin_oe_n);
  c_lock: cover property (serial_locked && serial_wr);
endmodule // pcs_sva
bind pcs_supervisor pcs_sva u_sva (.*);

// ---- tb_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; $display("unexpected %s %0h %0h", n, e, s); end end
module tb_top;
  logic clk = 0, rst = 1, vdd_below_trip = 0, wd_enable = 0, cal_mode = 0, early_fail_sense_in = 0, pull = 0, ken = 0;
  logic event_count_in_a = 0, event_count_in_b = 0, count_falling_a = 0, count_falling_b = 1, serial_wr = 0;
  logic serial_lock = 0, wd_restart, pin, rst_pin_out, rst_pin_oe_n, reset_by_watchdog, early_fail_warn_out, serial_locked;
  logic [4:0] wd_period = 5'h01;
  logic [15:0] event_count_a, event_count_b;
  logic [63:0] serial_wr_data = 64'hA5A5_0F0F_1234_5678, serial_number;
  int failures = 0, checked = 0, cyc = 0, n;
  pcs_supervisor #(.TICK_CYCLES(10), .CAL_HALF_CYCLES(4)) dut (.*, .rst_pin_in(pin));
  pcs_host host (.clk(clk), .oe_n(rst_pin_oe_n), .drv(rst_pin_out), .pull(pull), .kick_en(ken), .pin(pin), .kick(wd_restart));
  always #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 25000) begin failures++; conclude(); end
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic till(logic v, int lim);
    for (n = 0; pin !== v && n < lim; n++) @(posedge clk);
  endtask
  task automatic t_wd;
    wd_enable <= 1; till(0, 1200); `CHK("wd_time", 1, n > 950 && n < 1050)
    repeat (2) @(posedge clk); `CHK("wd_flag", 1'b1, reset_by_watchdog)
    till(1, 1200); ken <= 1; till(0, 3000); `CHK("kicked", 3000, n)
    wd_enable <= 0; ken <= 0; till(0, 3000); `CHK("wd_off", 3000, n)
    wd_period <= 5'h02; wd_enable <= 1; till(0, 2500); `CHK("wd_long", 1, n > 1950 && n < 2050)
    till(1, 1200); wd_enable <= 0;
  endtask
  task automatic t_manual;
    pull <= 1; repeat (60) @(posedge clk); pull <= 0; @(posedge clk);
    `CHK("mr_drive", 1'b0, rst_pin_oe_n)
    till(1, 1200); `CHK("mr_hold", 1, n > 900 && n < 1035)
  endtask
  task automatic t_warn;
    `CHK("warn_low", 1'b1, early_fail_warn_out)
    early_fail_sense_in <= 1; repeat (2) @(posedge clk);
    `CHK("warn_high", 1'b0, early_fail_warn_out)
    cal_mode <= 1; repeat (2) @(posedge clk);
    for (n = 0; early_fail_warn_out !== 1'b1 && n < 20; n++) @(posedge clk);
    for (n = 0; early_fail_warn_out === 1'b1 && n < 20; n++) @(posedge clk);
    `CHK("cal_half", 4, n)
    cal_mode <= 0; early_fail_sense_in <= 0; repeat (2) @(posedge clk);
    `CHK("warn_back", 1'b1, early_fail_warn_out)
  endtask
  task automatic t_supply;
    vdd_below_trip <= 1; repeat (40) @(posedge clk);
    vdd_below_trip <= 0; till(1, 1200); `CHK("hold", 1, n > 985 && n < 1035)
    `CHK("src", 1'b0, reset_by_watchdog)
  endtask
  task automatic t_glitch;
    pull <= 1; @(posedge clk) pull <= 0; @(posedge clk); till(0, 99); `CHK("glitch", 99, n)
  endtask
  task automatic t_count;
    repeat (7) begin @(posedge clk) event_count_in_a <= ~event_count_in_a; event_count_in_b <= ~event_count_in_b; end
    repeat (6) @(posedge clk);
    `CHK("cnt_a", 16'h0004, event_count_a)
    `CHK("cnt_b", 16'h0003, event_count_b)
  endtask
  task automatic t_serial;
    serial_wr <= 1; @(posedge clk) serial_wr <= 0; serial_lock <= 1;
    @(posedge clk) serial_lock <= 0; serial_wr <= 1; serial_wr_data <= 64'h0;
    @(posedge clk) serial_wr <= 0; @(posedge clk);
    `CHK("serial", 64'hA5A5_0F0F_1234_5678, serial_number)
    `CHK("locked", 1'b1, serial_locked)
  endtask
  initial begin
    repeat (3) @(posedge clk); rst <= 0; @(posedge clk);
    t_wd; t_supply; t_glitch; t_manual; t_count; t_serial; t_warn; conclude;
  end
endmodule // tb_top
